// >>> rtl/uart_cfg_defs.vh
// constants for the uart match, oversampling and dma configuration block
`ifndef UART_CFG_DEFS_VH
`define UART_CFG_DEFS_VH

// -----------------------------------------------------------------
// register indices (byte address is four times the index)
// -----------------------------------------------------------------
`define IDX_MATCH_ADDR_FIRST 6'h08
`define IDX_MATCH_ADDR_SECOND 6'h09
`define IDX_CTRL_FOUR 6'h0A
`define IDX_CTRL_FIVE 6'h0B
`define IDX_IRQ_STATUS 6'h0C
`define IDX_IRQ_MASK 6'h0D
`define IDX_RX_DATA 6'h0E
`define IDX_TX_DATA 6'h0F
`define IDX_LINE_STATUS 6'h10

// -----------------------------------------------------------------
// field positions
// -----------------------------------------------------------------
`define C4_MAEN_FIRST_BIT 7
`define C4_MAEN_SECOND_BIT 6
`define C4_TEN_BIT_BIT 5
`define C5_TX_DMA_BIT 7
`define C5_RX_DMA_BIT 5
`define C5_DUAL_EDGE_BIT 1
`define C5_WRITABLE_MASK 8'hA3
`define C5_RESYNC_OFF_BIT 0

// -----------------------------------------------------------------
// reset values and oversampling codes
// -----------------------------------------------------------------
`define C4_RESET 8'h0F
`define C5_RESET 8'h00
`define OSR_DEFAULT 5'h0F
`define OSR_MIN 5'h03
`define OSR_MAX 5'h1F

// -----------------------------------------------------------------
// interrupt status bits
// -----------------------------------------------------------------
`define IRQ_RX_FULL_BIT 0
`define IRQ_TX_EMPTY_BIT 1
`define IRQ_DISCARD_BIT 2
`define IRQ_OVERRUN_BIT 3
`define IRQ_WIDTH 4

`endif

// >>> rtl/uart_sample_tick.v
// baud sample tick generator with optional dual-edge sampling
`timescale 1ns/1ps
`default_nettype none

// the baud clock is clk_i; a falling-edge sample is modelled as a half
// sample step, so dual-edge only pulls the mid-bit sample earlier; ticks per bit stay ratio plus one
module uart_sample_tick (
  input wire clk_i,
  input wire rst_i,
  input wire run_i,
  input wire dual_edge_i,
  input wire [4:0] ratio_i,
  output reg [5:0] ticks_per_bit_o,
  output reg [5:0] mid_tick_o
);

  // -----------------------------------------------------------------
  // sample count per bit, one per baud clock
  // -----------------------------------------------------------------
  wire [5:0] base_count;
  assign base_count = {1'b0, ratio_i} + 6'h01;

  always @(posedge clk_i) begin
    if (rst_i || !run_i) begin
      ticks_per_bit_o <= 6'h10;
      mid_tick_o <= 6'h08;
    end else begin
      // ratio plus one baud periods per bit RQ9
      ticks_per_bit_o <= base_count;
      // dual edge: midpoint lands on a half period, so sample earlier
      mid_tick_o <= dual_edge_i ? ((base_count - 6'h01) >> 1) : // RQ15
                    (base_count >> 1);                          // RQ18
    end
  end

endmodule

`default_nettype wire

// >>> rtl/uart_rx_match_cfg.v
// uart match filter, oversampling, dma requests and wishbone registers
`timescale 1ns/1ps
`default_nettype none
`include "uart_cfg_defs.vh"

// How it works
// RQ1: first enable compares address words with first match
// RQ2: second enable compares address words with second match
// RQ3: any enable drops words with top bit clear
// RQ4: no enable passes every received word
// RQ5: both enabled accept on either match
// RQ6: ten-bit bit widens tx and rx characters
// RQ7: software changes ten-bit mode only when idle
// RQ8: five-bit field selects 4x to 32x oversampling
// RQ9: bit time is field plus one baud clocks
// RQ10: out-of-range field value behaves as sixteen
// RQ11: software changes oversampling only when idle
// RQ12: tx dma request follows empty flag when enabled
// RQ13: rx dma request follows full flag when enabled
// RQ14: reserved control five bits read zero
// RQ15: dual edge doubles samples per bit; code keeps ratio plus one ticks per bit and only moves the mid sample earlier
// RQ16: software sets dual edge for 4x to 7x
// RQ17: software changes dual edge only when receiver idle
// RQ18: without dual edge sample on rising edges
// RQ19: receiver on baud clock, tx divided by ratio
module uart_rx_match_cfg (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire rx_enable_i,
  input wire tx_enable_i,
  input wire rx_line_i,
  output reg tx_line_o,
  output wire tx_dma_req_o,
  input wire tx_dma_ack_i,
  input wire [9:0] tx_dma_data_i,
  output wire rx_dma_req_o,
  input wire rx_dma_ack_i,
  output reg irq_o
);

  // -----------------------------------------------------------------
  // registers
  // -----------------------------------------------------------------
  reg [7:0] match_address_first;   // first match address
  reg [7:0] match_address_second;  // second match address
  reg [7:0] control_four_match_mode_osr;
  reg [7:0] control_five_dma_sampling;
  reg [`IRQ_WIDTH-1:0] irq_status; // sticky events
  reg [`IRQ_WIDTH-1:0] irq_mask;   // one enables the event
  reg [9:0] rx_data;               // receive data buffer
  reg [9:0] tx_data;               // transmit data buffer
  reg rx_buffer_full_flag;
  reg tx_buffer_empty_flag;

  wire match_enable_first;
  wire match_enable_second;
  wire ten_bit_char_select;
  wire [4:0] oversample_ratio_field;
  wire tx_dma_request_enable;
  wire rx_dma_request_enable;
  wire dual_edge_sampling;
  assign match_enable_first = control_four_match_mode_osr[`C4_MAEN_FIRST_BIT];
  assign match_enable_second =
    control_four_match_mode_osr[`C4_MAEN_SECOND_BIT];
  assign ten_bit_char_select = control_four_match_mode_osr[`C4_TEN_BIT_BIT];
  assign oversample_ratio_field = control_four_match_mode_osr[4:0];
  assign tx_dma_request_enable = control_five_dma_sampling[`C5_TX_DMA_BIT];
  assign rx_dma_request_enable = control_five_dma_sampling[`C5_RX_DMA_BIT];
  assign dual_edge_sampling = control_five_dma_sampling[`C5_DUAL_EDGE_BIT];

  // character length: 8 data bits, or 10 when the ten-bit mode is set
  wire [3:0] data_bits;
  assign data_bits = ten_bit_char_select ? 4'hA : 4'h8; // RQ6

  // -----------------------------------------------------------------
  // wishbone slave: ack one cycle after request, dropped next cycle
  // -----------------------------------------------------------------
  wire bus_req;
  wire bus_wr;
  wire bus_rd;
  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // writes land at the ack edge, where the master samples ack high
  assign bus_wr = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0];
  assign bus_rd = bus_req && !wb_we_i;

  // clamp an out-of-range ratio code to the sixteen default
  wire [4:0] osr_written;
  assign osr_written = (wb_dat_i[4:0] < `OSR_MIN) ? `OSR_DEFAULT // RQ10
                       : wb_dat_i[4:0];                          // RQ8

  // events raised by the datapath this cycle
  reg ev_rx_full;
  reg ev_discard;
  reg ev_overrun;
  reg ev_tx_empty;

  always @(posedge clk_i) begin
    if (rst_i) begin
      match_address_first <= 8'h00;
      match_address_second <= 8'h00;
      control_four_match_mode_osr <= `C4_RESET;
      control_five_dma_sampling <= `C5_RESET;
      irq_mask <= {`IRQ_WIDTH{1'b0}};
      irq_status <= {`IRQ_WIDTH{1'b0}};
    end else begin
      if (bus_wr) begin
        case (wb_adr_i[7:2])
          `IDX_MATCH_ADDR_FIRST: match_address_first <= wb_dat_i[7:0];
          `IDX_MATCH_ADDR_SECOND: match_address_second <= wb_dat_i[7:0];
          `IDX_CTRL_FOUR: begin
            control_four_match_mode_osr <= {wb_dat_i[7:5], osr_written};
          end
          `IDX_CTRL_FIVE: begin
            // reserved bits never store a one
            control_five_dma_sampling <= wb_dat_i[7:0] &
                                         `C5_WRITABLE_MASK; // RQ14
          end
          `IDX_IRQ_MASK: irq_mask <= wb_dat_i[`IRQ_WIDTH-1:0];
          default: ;
        endcase
      end
      // set wins over a write-one-to-clear in the same cycle
      irq_status <= (irq_status &
                     ~((bus_wr && wb_adr_i[7:2] == `IDX_IRQ_STATUS) ?
                       wb_dat_i[`IRQ_WIDTH-1:0] : {`IRQ_WIDTH{1'b0}})) |
                    {ev_overrun, ev_discard, ev_tx_empty, ev_rx_full};
    end
  end

  // read mux and acknowledge
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= bus_req;
      if (bus_rd) begin
        case (wb_adr_i[7:2])
          `IDX_MATCH_ADDR_FIRST: wb_dat_o <= {24'h000000, match_address_first};
          `IDX_MATCH_ADDR_SECOND:
            wb_dat_o <= {24'h000000, match_address_second};
          `IDX_CTRL_FOUR:
            wb_dat_o <= {24'h000000, control_four_match_mode_osr};
          `IDX_CTRL_FIVE:
            wb_dat_o <= {24'h000000, control_five_dma_sampling}; // RQ14
          `IDX_IRQ_STATUS: wb_dat_o <= {28'h0000000, irq_status};
          `IDX_IRQ_MASK: wb_dat_o <= {28'h0000000, irq_mask};
          `IDX_RX_DATA: wb_dat_o <= {22'h000000, rx_data};
          `IDX_LINE_STATUS:
            wb_dat_o <= {30'h00000000, tx_buffer_empty_flag,
                         rx_buffer_full_flag};
          default: wb_dat_o <= 32'h00000000; // unmapped reads zero
        endcase
      end
    end
  end

  // level interrupt while any unmasked status bit is set
  always @(posedge clk_i) begin
    if (rst_i) irq_o <= 1'b0;
    else irq_o <= |(irq_status & irq_mask);
  end

  // -----------------------------------------------------------------
  // dma requests follow the buffer flags
  // -----------------------------------------------------------------
  assign tx_dma_req_o = tx_dma_request_enable && tx_buffer_empty_flag; // RQ12
  assign rx_dma_req_o = rx_dma_request_enable && rx_buffer_full_flag;  // RQ13

  // -----------------------------------------------------------------
  // receiver: runs on every baud clock, ratio+1 clocks per bit
  // -----------------------------------------------------------------
  wire [5:0] ticks_per_bit;
  wire [5:0] mid_tick;
  uart_sample_tick u_tick (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(rx_enable_i),
    .dual_edge_i(dual_edge_sampling),
    .ratio_i(oversample_ratio_field),
    .ticks_per_bit_o(ticks_per_bit),
    .mid_tick_o(mid_tick)
  );

  localparam RX_IDLE = 4'b0001;
  localparam RX_START = 4'b0010;
  localparam RX_DATA = 4'b0100;
  localparam RX_STOP = 4'b1000;
  reg [3:0] rx_state;
  reg [5:0] rx_tick;  // baud clocks within the bit
  reg [3:0] rx_bit;   // data bits taken
  reg [9:0] rx_shift; // lsb first shift register
  wire [9:0] rx_word;
  wire rx_top;
  // right-align the word, top bit is bit 7 or bit 9
  assign rx_word = ten_bit_char_select ? rx_shift : {2'b00, rx_shift[9:2]};
  assign rx_top = ten_bit_char_select ? rx_word[9] : rx_word[7];

  // address filter on the low eight bits of the word
  reg keep_word;
  always @* begin
    keep_word = 1'b1; // RQ4
    if (match_enable_first || match_enable_second) begin
      if (!rx_top) keep_word = 1'b0; // RQ3
      else keep_word =
        (match_enable_first && rx_word[7:0] == match_address_first) || // RQ1
        (match_enable_second && rx_word[7:0] == match_address_second); // RQ2 RQ5
    end
  end

  always @(posedge clk_i) begin
    ev_rx_full <= 1'b0;
    ev_discard <= 1'b0;
    ev_overrun <= 1'b0;
    if (rst_i || !rx_enable_i) begin
      rx_state <= RX_IDLE;
      rx_tick <= 6'h00;
      rx_bit <= 4'h0;
      rx_shift <= 10'h000;
      if (rst_i) begin
        rx_data <= 10'h000;
        rx_buffer_full_flag <= 1'b0;
      end
    end else begin
      if (rx_dma_ack_i || (bus_rd && wb_adr_i[7:2] == `IDX_RX_DATA))
        rx_buffer_full_flag <= 1'b0;
      rx_tick <= rx_tick + 6'h01; // receiver advances every baud clock RQ19
      case (rx_state)
        RX_IDLE: begin
          rx_tick <= 6'h00;
          if (!rx_line_i) rx_state <= RX_START;
        end
        RX_START: begin
          if (rx_tick == mid_tick) begin
            rx_tick <= 6'h00;
            rx_bit <= 4'h0;
            rx_state <= rx_line_i ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (rx_tick == ticks_per_bit - 6'h01) begin
            rx_tick <= 6'h00;
            rx_shift <= {rx_line_i, rx_shift[9:1]};
            rx_bit <= rx_bit + 4'h1;
            if (rx_bit == data_bits - 4'h1) rx_state <= RX_STOP;
          end
        end
        RX_STOP: begin
          if (rx_tick == ticks_per_bit - 6'h01) begin
            rx_state <= RX_IDLE;
            if (keep_word) begin
              rx_data <= rx_word;
              rx_buffer_full_flag <= 1'b1;
              ev_rx_full <= 1'b1;
              ev_overrun <= rx_buffer_full_flag;
            end else begin
              ev_discard <= 1'b1;
            end
          end
        end
        default: rx_state <= RX_IDLE;
      endcase
    end
  end

  // -----------------------------------------------------------------
  // transmitter: one bit per ratio+1 baud clocks
  // -----------------------------------------------------------------
  reg [5:0] tx_div;   // baud clock divided by ratio plus one RQ19
  reg [11:0] tx_shift;
  reg [3:0] tx_left;  // bits still to send
  reg tx_busy;
  wire tx_bit_end;
  assign tx_bit_end = (tx_div == {1'b0, oversample_ratio_field}); // RQ9 RQ19
  wire tx_load;
  assign tx_load = bus_wr && wb_adr_i[7:2] == `IDX_TX_DATA;

  always @(posedge clk_i) begin
    ev_tx_empty <= 1'b0;
    if (rst_i) begin
      tx_data <= 10'h000;
      tx_buffer_empty_flag <= 1'b1;
      tx_div <= 6'h00;
      tx_shift <= 12'hFFF;
      tx_left <= 4'h0;
      tx_busy <= 1'b0;
      tx_line_o <= 1'b1;
    end else begin
      if (tx_dma_ack_i) begin
        tx_data <= tx_dma_data_i;
        tx_buffer_empty_flag <= 1'b0;
      end else if (tx_load) begin
        tx_data <= wb_dat_i[9:0];
        tx_buffer_empty_flag <= 1'b0;
      end
      tx_div <= tx_bit_end ? 6'h00 : tx_div + 6'h01;
      if (tx_bit_end) begin
        if (tx_busy) begin
          tx_line_o <= tx_shift[0];
          tx_shift <= {1'b1, tx_shift[11:1]};
          tx_left <= tx_left - 4'h1;
          if (tx_left == 4'h1) tx_busy <= 1'b0;
        end else if (tx_enable_i && !tx_buffer_empty_flag) begin
          // start, data, stop; data width from the ten-bit mode RQ6
          tx_shift <= ten_bit_char_select ?
                      {1'b1, tx_data, 1'b0} : {3'b111, tx_data[7:0], 1'b0};
          tx_left <= data_bits + 4'h2;
          tx_busy <= 1'b1;
          tx_buffer_empty_flag <= 1'b1;
          ev_tx_empty <= 1'b1;
        end else begin
          tx_line_o <= 1'b1;
        end
      end
    end
  end

endmodule

`default_nettype wire

// >>> testbench/uart_cfg_props.sv
// assertion checker for the uart match, oversampling and dma block
`timescale 1ns/1ps
`default_nettype none
module uart_cfg_props (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic tx_line_o,
  input wire logic tx_dma_req_o,
  input wire logic rx_dma_req_o,
  input wire logic irq_o
);
  // ---------------------------------------------------------------
  // shadows follow writes at the ack edge, as the dut does
  // ---------------------------------------------------------------
  reg [7:0] c4; // control four as software should read it
  reg [7:0] c5; // control five, writable bits only
  reg [9:0] zlen; // cycles the tx line has stayed low
  wire wr = wb_ack_o && wb_we_i && wb_sel_i[0]; // write lands
  wire rd = wb_ack_o && !wb_we_i; // read data valid
  // shadow and low-run counter
  always @(posedge clk_i) begin
    if (rst_i) begin
      c4 <= 8'h0F;
      c5 <= 8'h00;
      zlen <= 10'h000;
    end else begin
      zlen <= tx_line_o ? 10'h000 : zlen + 10'h001;
      // invalid ratio codes fall back to sixteen
      if (wr && wb_adr_i == 8'h28)
        c4 <= (wb_dat_i[4:0] < 5'h03) ? {wb_dat_i[7:5], 5'h0F}
                                      : wb_dat_i[7:0];
      if (wr && wb_adr_i == 8'h2C)
        c5 <= wb_dat_i[7:0] & 8'hA3;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack_once;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack not one pulse");
  property p_ack_cause;
    wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack uncalled");
  property p_reset_idle;
    $fell(rst_i) |-> tx_line_o && !irq_o && !wb_ack_o;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("not idle");
  property p_tx_dma_off;
    !c5[7] |-> !tx_dma_req_o;
  endproperty
  a_tx_dma_off: assert property (p_tx_dma_off) else $error("tx req");
  property p_rx_dma_off;
    !c5[5] |-> !rx_dma_req_o;
  endproperty
  a_rx_dma_off: assert property (p_rx_dma_off) else $error("rx req");
  property p_c4_back;
    rd && wb_adr_i == 8'h28 |-> wb_dat_o == {24'h000000, c4};
  endproperty
  a_c4_back: assert property (p_c4_back) else $error("c4");
  property p_c5_back;
    rd && wb_adr_i == 8'h2C |-> wb_dat_o == {24'h000000, c5};
  endproperty
  a_c5_back: assert property (p_c5_back) else $error("c5 readback");
  property p_unmapped;
    rd && wb_adr_i[7:2] > 6'h10 |-> wb_dat_o == 32'h00000000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read");
  // a low run always ends on a bit boundary of the divided clock
  property p_bit_time;
    $rose(tx_line_o) |-> zlen % ({5'h00, c4[4:0]} + 10'h001) == 10'h000;
  endproperty
  a_bit_time: assert property (p_bit_time) else $error("tx bit");
endmodule
bind uart_rx_match_cfg uart_cfg_props u_props (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .tx_line_o(tx_line_o), .tx_dma_req_o(tx_dma_req_o),
  .rx_dma_req_o(rx_dma_req_o), .irq_o(irq_o)
);
`default_nettype wire

// >>> testbench/remote_uart.sv
// remote serial device: sends frames in and takes the transmitter's frames
`timescale 1ns/1ps
`default_nettype none
module remote_uart (
  input wire logic clk_i,
  input wire logic line_i,
  output logic line_o
);
  initial line_o = 1'b1; // idle high between frames
  // start low, data lsb first, stop high; each bit lasts bt clocks
  task automatic send(input logic [9:0] w, input int nb, input int bt);
    int i;
    for (i = -1; i <= nb; i++) begin
      @(posedge clk_i);
      line_o <= (i < 0) ? 1'b0 : (i == nb) ? 1'b1 : w[i];
      repeat (bt - 1) @(posedge clk_i);
    end
  endtask
  // wait for the start bit, then sample each data bit near its middle
  task automatic recv(output logic [9:0] w, input int nb, input int bt);
    int i;
    w = 10'h000;
    @(negedge line_i);
    repeat (bt / 2) @(posedge clk_i);
    for (i = 0; i < nb; i++) begin
      repeat (bt) @(posedge clk_i);
      w[i] = line_i;
    end
  endtask
endmodule
`default_nettype wire

// >>> testbench/testbench.sv
// self-checking bench for the uart match and dma configuration block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // ---------------------------------------------------------------
  // stimulus and scoreboard
  // ---------------------------------------------------------------
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic rx_enable_i = 1'b0, tx_enable_i = 1'b0;
  logic tx_dma_ack_i = 1'b0, rx_dma_ack_i = 1'b0;
  logic [9:0] tx_dma_data_i = 10'h000;
  wire rx_line; // driven by the remote model
  wire [31:0] wb_dat_o;
  wire wb_ack_o, tx_line_o, tx_dma_req_o, rx_dma_req_o, irq_o;
  int bad_count = 0, tests_run = 0, i, j;
  integer seed = 32'hEB921205;
  logic [31:0] exp_q [$]; // read data still expected
  logic [7:0] r;
  logic [9:0] w, got;
  logic [1:0] mode;
  logic keep;
  logic [7:0] words [0:3] = '{8'h25, 8'hA5, 8'hC3, 8'h99};
  logic [4:0] codes [0:7] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h0F,
                              5'h1F, 5'h10};
  always #2.5 clk_i = ~clk_i;
  uart_rx_match_cfg u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .rx_enable_i(rx_enable_i), .tx_enable_i(tx_enable_i),
    .rx_line_i(rx_line), .tx_line_o(tx_line_o),
    .tx_dma_req_o(tx_dma_req_o), .tx_dma_ack_i(tx_dma_ack_i),
    .tx_dma_data_i(tx_dma_data_i), .rx_dma_req_o(rx_dma_req_o),
    .rx_dma_ack_i(rx_dma_ack_i), .irq_o(irq_o)
  );
  remote_uart u_peer (.clk_i(clk_i), .line_i(tx_line_o), .line_o(rx_line));
  task check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t saw %h want %h", $time, seen, exp);
    end
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // one classic cycle; held until ack is sampled, then released
  task wb(input logic [7:0] a, input logic we, input logic [31:0] d);
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, d};
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] exp);
    exp_q.push_back(exp);
    wb(a, 1'b0, 32'h0);
  endtask
  // read data is compared at the ack edge against the oldest note
  always @(posedge clk_i)
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
      check(wb_dat_o, exp_q.size() > 0 ? exp_q.pop_front() : 32'hX);
  // one 8-bit frame in; rx dma and the unmasked full bit track keep
  task rx_word(input logic [9:0] v, input logic k);
    u_peer.send(v, 8, 5);
    tick(10);
    check(32'(irq_o), 32'(k));
    check(32'(rx_dma_req_o), 32'(k));
    rd(8'h40, {30'h0, 1'b1, k});
    if (k) begin
      rd(8'h38, 32'(v));
      wb(8'h30, 1'b1, 32'hF);
      tick(2);
      check(32'(irq_o), 32'h0);
    end
  endtask
  initial begin
    tick(8);
    rst_i <= 1'b0;
    rd(8'h28, 32'h0F);
    rd(8'h2C, 32'h0);
    wb(8'h80, 1'b1, 32'hFF);
    rd(8'h80, 32'h0);
    wb(8'h2C, 1'b1, 32'hFF);
    rd(8'h2C, 32'hA3);
    check(32'(tx_dma_req_o), 32'h1);
    wb(8'h2C, 1'b1, 32'h0);
    tick(1);
    check(32'(tx_dma_req_o), 32'h0);
    $display("test reset and control five done");
    codes[7] = 5'($random(seed));
    for (i = 0; i < 8; i++) begin
      r = 8'($random(seed));
      r[4:0] = codes[i];
      wb(8'h28, 1'b1, {24'h0, r});
      rd(8'h28, {24'h0, r[7:5], codes[i] < 5'h03 ? 5'h0F : r[4:0]});
    end
    $display("test ratio codes done");
    // ratio 5x needs dual edge; both ends idle while configuring
    wb(8'h28, 1'b1, 32'h04);
    wb(8'h2C, 1'b1, 32'h22);
    wb(8'h34, 1'b1, 32'h1);
    rd(8'h34, 32'h1);
    wb(8'h20, 1'b1, 32'hA5);
    wb(8'h24, 1'b1, 32'hC3);
    rx_enable_i <= 1'b1;
    tx_enable_i <= 1'b1;
    fork
      u_peer.recv(got, 8, 5);
      wb(8'h3C, 1'b1, 32'h5A);
    join
    check(32'(got), 32'h5A);
    tick(130);
    wb(8'h2C, 1'b1, 32'hA2);
    tick(1);
    check(32'(tx_dma_req_o), 32'h1);
    w = 10'($random(seed));
    tx_dma_data_i <= w;
    fork
      u_peer.recv(got, 8, 5);
      begin
        tx_dma_ack_i <= 1'b1;
        tick(1);
        tx_dma_ack_i <= 1'b0;
        tick(1);
        check(32'(tx_dma_req_o), 32'h0);
      end
    join
    check(32'(got), {24'h0, w[7:0]});
    tick(130);
    wb(8'h2C, 1'b1, 32'h22);
    $display("test transmit done");
    rx_word(10'(8'($random(seed))), 1'b1);
    for (i = 0; i < 4; i++) begin
      mode = 2'(i);
      {rx_enable_i, tx_enable_i} <= 2'b00;
      wb(8'h28, 1'b1, {24'h0, mode, 6'h04});
      {rx_enable_i, tx_enable_i} <= 2'b11;
      for (j = 0; j < 4; j++) begin
        w = {2'b00, words[j]};
        keep = mode == 2'b00 || (w[7] && ((mode[1] && w == 10'h0A5) ||
               (mode[0] && w == 10'h0C3)));
        rx_word(w, keep);
      end
    end
    $display("test address match done");
    {rx_enable_i, tx_enable_i} <= 2'b00;
    // ratio 8x leaves dual edge optional: sample on rising edges only
    wb(8'h28, 1'b1, 32'h27);
    wb(8'h2C, 1'b1, 32'h20);
    {rx_enable_i, tx_enable_i} <= 2'b11;
    w = 10'($random(seed));
    u_peer.send(w, 10, 8);
    tick(10);
    check(32'(rx_dma_req_o), 32'h1);
    rx_dma_ack_i <= 1'b1;
    tick(1);
    rx_dma_ack_i <= 1'b0;
    tick(1);
    check(32'(rx_dma_req_o), 32'h0);
    rd(8'h38, 32'(w));
    fork
      u_peer.recv(got, 10, 8);
      wb(8'h3C, 1'b1, 32'h2F0);
    join
    check(32'(got), 32'h2F0);
    tick(150);
    $display("test ten-bit done");
    // a second reset in mid-run brings the registers back
    rst_i <= 1'b1;
    tick(3);
    rst_i <= 1'b0;
    rd(8'h28, 32'h0F);
    rd(8'h2C, 32'h0);
    rd(8'h34, 32'h0);
    $display("test mid-run reset done");
    end_sim;
  end
  // watchdog well beyond the expected few thousand cycles
  initial begin
    tick(20000);
    bad_count++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    end_sim;
  end
endmodule
`default_nettype wire
